// ===== logic/jlocfg_map.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          lane, sync-header and over-range configuration block.
// Assumes: 12-bit register addresses, 8-bit register data.
// Notes:   Definitions only; included by bare name.
`ifndef JLOCFG_MAP_SVH
`define JLOCFG_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define JLOCFG_ADDR_LANE_EXTRA_B   12'h20B
`define JLOCFG_ADDR_SYNC_HDR       12'h20F
`define JLOCFG_ADDR_OVR_LEVEL0     12'h211
`define JLOCFG_ADDR_OVR_LEVEL1     12'h212
`define JLOCFG_ADDR_OVERRANGE_CONFIG        12'h213

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define JLOCFG_RST_LANE_EXTRA_B    8'h00
`define JLOCFG_RST_SYNC_HDR        2'h0
`define JLOCFG_RST_OVR_LEVEL0      8'hF2
`define JLOCFG_RST_OVR_LEVEL1      8'hAB
`define JLOCFG_RST_OVR_PIN_EN      1'h0
`define JLOCFG_RST_OVR_HOLD        3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define JLOCFG_SPARE_SER_BIT       0
`define JLOCFG_EXTRA_LANE_MSB      7
`define JLOCFG_EXTRA_LANE_LSB      1
`define JLOCFG_SYNC_HDR_MSB        1
`define JLOCFG_OVR_PIN_EN_BIT      3
`define JLOCFG_OVR_HOLD_MSB        2

// ----------------------------------------------------------------
// Encodings and counts
// ----------------------------------------------------------------
`define JLOCFG_TEST_NONE           4'h0
`define JLOCFG_TEST_RAMP_ALT       4'h5
`define JLOCFG_TEST_OCTET_RAMP     4'h4
`define JLOCFG_HOLD_BASE_CYCLES    11'h008
`define JLOCFG_SYNC_WORD_BITS      32
`define JLOCFG_LEVEL_FULL_SCALE    256

`endif

// ===== logic/jlocfg_pkg.sv
// Purpose: Types shared by the lane and over-range configuration block.
// Assumes: Constants live in jlocfg_map.svh.
// Notes:   Nothing here is imported; users write jlocfg_pkg::name.
package jlocfg_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [7:0] jlocfg_byte_t;

	// Sync word content selection; 1 and 3 are reserved codes
	typedef enum logic [1:0] {
		JLOCFG_SH_CRC12 = 2'h0,
		JLOCFG_SH_RSVD1 = 2'h1,
		JLOCFG_SH_FEC   = 2'h2,
		JLOCFG_SH_RSVD3 = 2'h3
	} jlocfg_sync_hdr_t;

endpackage

// ===== logic/jlocfg_top.sv
// Purpose: Link B extra-lane enables, 64b/66b sync-header selection and
//          over-range detection with pin pulse stretching.
// Assumes: Register port driven by the control-port decoder on CLK;
//          sample magnitudes and link status come from logic on CLK.
// Notes:   All outputs registered; register reads answer one cycle late.
//
// How it works
// - Extra-lane bits 7..1 enable link-layer clock of lane Bn.
// - Extra-lane enables apply even when the link format skips that lane.
// - Spare serializer bit low: clocks only; high: serializers powered too.
// - Extra lanes follow format rate and test selection, ramp excepted.
// - Extra-only lane sends octet ramp when test select is 0 or 5.
// - Channel power-down wins over extra-lane enables.
// - Serializer n clocked only if lanes 0..n-1 are all enabled.
// - Sync-header field: 0 CRC-12, 2 FEC, 1 and 3 reserved, reset 0.
// - Sync word is 32 bits; selection only matters in 64b/66b formats.
// - No command channel; command fields always sent as zero.
// - Level zero register, reset F2, sets over flag zero threshold.
// - Level one register, reset AB, sets over flag one threshold.
// - Threshold scale: 256 is full-scale peak magnitude.
// - Config bit 3 enables the four over pins; low drives them low.
// - Pin enable leaves the over bits carried in link data alone.
// - Hold exponent, reset 7, stretches pin pulses to 8*2^n cycles.
`timescale 1ns/100ps
`include "jlocfg_map.svh"

module jlocfg_top #(
	parameter int NUM_LANES = 8,
	parameter int HOLD_W    = 11
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        REG_WE,
	input  wire logic        REG_RE,
	input  wire logic [11:0] REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        LINK_GLOBAL_ENABLE,
	input  wire logic        CHANNEL_POWERDOWN_B,
	input  wire logic [7:0]  LINK_FORMAT_LANES_B,
	input  wire logic        LINK_FORMAT_IS_64B66B,
	input  wire logic [3:0]  LINK_TEST_PATTERN_SELECT,
	input  wire logic [7:0]  SAMPLE_MAG_A,
	input  wire logic [7:0]  SAMPLE_MAG_B,
	output logic      [7:0]  LANE_CLK_EN_B,
	output logic      [7:0]  SER_CLK_EN_B,
	output logic      [7:0]  LANE_RAMP_B,
	output logic      [3:0]  LANE_TEST_SEL_B,
	output logic             SYNC_CRC12_EN,
	output logic             SYNC_FEC_EN,
	output logic      [7:0]  SYNC_CMD_BITS,
	output logic      [1:0]  LINK_OVER_BITS_A,
	output logic      [1:0]  LINK_OVER_BITS_B,
	output logic             CHAN_A_OVER_FLAG_ZERO,
	output logic             CHAN_A_OVER_FLAG_ONE,
	output logic             CHAN_B_OVER_FLAG_ZERO,
	output logic             CHAN_B_OVER_FLAG_ONE
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// Lane register is one byte and the longest hold is 1024 cycles
	if (NUM_LANES != 8) begin : g_bad_lanes
		$error("jlocfg_top: NUM_LANES must be 8");
	end
	if (HOLD_W < 11) begin : g_bad_hold
		$error("jlocfg_top: HOLD_W must be at least 11");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Magnitude at or above the level counts as over-range; the level
	// scale puts full-scale peak at 256, so 8'hFF is just below it
	function automatic logic over_hit(input logic [7:0] mag,
					  input logic [7:0] level);
		over_hit = (mag >= level);
	endfunction

	// Minimum pin pulse length in cycles, less one, for exponent n
	function automatic logic [HOLD_W-1:0] hold_len_m1(input logic [2:0] n);
		logic [HOLD_W-1:0] len;
		len = HOLD_W'(`JLOCFG_HOLD_BASE_CYCLES) << n;
		hold_len_m1 = len - HOLD_W'(1);
	endfunction

	// Counter step shared by the four hold counters
	function automatic logic [HOLD_W-1:0] hold_next(input logic hit,
				input logic [HOLD_W-1:0] cnt, input logic [2:0] n);
		if (hit) begin
			hold_next = hold_len_m1(n);
		end else if (cnt != '0) begin
			hold_next = cnt - HOLD_W'(1);
		end else begin
			hold_next = '0;
		end
	endfunction

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:1]                    extra_lane_q, extra_lane_d;
	logic                          spare_ser_q, spare_ser_d;
	jlocfg_pkg::jlocfg_sync_hdr_t  sync_hdr_q, sync_hdr_d;
	jlocfg_pkg::jlocfg_byte_t      level0_q, level0_d;
	jlocfg_pkg::jlocfg_byte_t      level1_q, level1_d;
	logic                          pin_en_q, pin_en_d;
	logic [2:0]                    hold_exp_q, hold_exp_d;
	jlocfg_pkg::jlocfg_byte_t      rdata_q, rdata_d;

	// Writes store only defined fields, so reserved bits stay zero.
	// Writes are not blocked while the link runs: keeping the link
	// disabled during lane or sync-header changes is the host's job
	always_comb begin
		extra_lane_d = extra_lane_q;
		spare_ser_d  = spare_ser_q;
		sync_hdr_d   = sync_hdr_q;
		level0_d     = level0_q;
		level1_d     = level1_q;
		pin_en_d     = pin_en_q;
		hold_exp_d   = hold_exp_q;
		if (REG_WE) begin
			unique case (REG_ADDR)
			`JLOCFG_ADDR_LANE_EXTRA_B: begin
				extra_lane_d = REG_WDATA[`JLOCFG_EXTRA_LANE_MSB:
					`JLOCFG_EXTRA_LANE_LSB];
				spare_ser_d  = REG_WDATA[`JLOCFG_SPARE_SER_BIT];
			end
			`JLOCFG_ADDR_SYNC_HDR: begin
				sync_hdr_d = jlocfg_pkg::jlocfg_sync_hdr_t'(
					REG_WDATA[`JLOCFG_SYNC_HDR_MSB:0]);
			end
			`JLOCFG_ADDR_OVR_LEVEL0: begin
				level0_d = REG_WDATA;
			end
			`JLOCFG_ADDR_OVR_LEVEL1: begin
				level1_d = REG_WDATA;
			end
			`JLOCFG_ADDR_OVERRANGE_CONFIG: begin
				pin_en_d   = REG_WDATA[`JLOCFG_OVR_PIN_EN_BIT];
				hold_exp_d = REG_WDATA[`JLOCFG_OVR_HOLD_MSB:0];
			end
			default: begin
				// Unmapped or reserved address: no effect
			end
			endcase
		end
	end

	// Read mux; unmapped addresses and reserved bits answer zero
	always_comb begin
		rdata_d = rdata_q;
		if (REG_RE) begin
			unique case (REG_ADDR)
			`JLOCFG_ADDR_LANE_EXTRA_B: rdata_d = {extra_lane_q, spare_ser_q};
			`JLOCFG_ADDR_SYNC_HDR:     rdata_d = {6'h00, sync_hdr_q};
			`JLOCFG_ADDR_OVR_LEVEL0:   rdata_d = level0_q;
			`JLOCFG_ADDR_OVR_LEVEL1:   rdata_d = level1_q;
			`JLOCFG_ADDR_OVERRANGE_CONFIG:      rdata_d = {4'h0, pin_en_q,
							hold_exp_q};
			default:                   rdata_d = 8'h00;
			endcase
		end
	end

	// Register bank flip-flops
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			extra_lane_q <= 7'(`JLOCFG_RST_LANE_EXTRA_B >> 1);
			spare_ser_q  <= 1'(`JLOCFG_RST_LANE_EXTRA_B);
			sync_hdr_q   <= jlocfg_pkg::JLOCFG_SH_CRC12;
			level0_q     <= `JLOCFG_RST_OVR_LEVEL0;
			level1_q     <= `JLOCFG_RST_OVR_LEVEL1;
			pin_en_q     <= `JLOCFG_RST_OVR_PIN_EN;
			hold_exp_q   <= `JLOCFG_RST_OVR_HOLD;
			rdata_q      <= 8'h00;
		end else begin
			extra_lane_q <= extra_lane_d;
			spare_ser_q  <= spare_ser_d;
			sync_hdr_q   <= sync_hdr_d;
			level0_q     <= level0_d;
			level1_q     <= level1_d;
			pin_en_q     <= pin_en_d;
			hold_exp_q   <= hold_exp_d;
			rdata_q      <= rdata_d;
		end
	end

	assign REG_RDATA = rdata_q;

	// ----------------------------------------------------------------
	// Lane enables
	// ----------------------------------------------------------------
	logic [7:0] lane_clk_q, lane_clk_d;
	logic [7:0] ser_clk_q, ser_clk_d;
	logic [7:0] ramp_q, ramp_d;
	logic [3:0] test_q, test_d;
	logic [7:0] lane_on;
	logic [7:0] extra_only;
	logic       ramp_test;

	// A lane runs if the format wants it or an extra bit asks for it,
	// and never while channel B is powered down
	always_comb begin
		lane_on    = LINK_FORMAT_LANES_B | {extra_lane_q, 1'h0};
		extra_only = {extra_lane_q, 1'h0} & ~LINK_FORMAT_LANES_B;
		ramp_test  = (LINK_TEST_PATTERN_SELECT == `JLOCFG_TEST_NONE) ||
			     (LINK_TEST_PATTERN_SELECT == `JLOCFG_TEST_RAMP_ALT);
		lane_clk_d = CHANNEL_POWERDOWN_B ? 8'h00 : lane_on;
		// Format lanes get serializers whatever the spare bit; extra ones only with
		// the spare bit. A lane whose lower neighbours are not all on
		// gets no serializer clock, so gaps silence the lanes above
		ser_clk_d = 8'h00;
		for (int n = 0; n < NUM_LANES; n++) begin
			ser_clk_d[n] = !CHANNEL_POWERDOWN_B && lane_on[n] &&
				(LINK_FORMAT_LANES_B[n] || spare_ser_q) &&
				((n == 0) || (&(lane_on | ~(8'hFF >> (8 - n)))));
		end
		// Extra-only lanes send the octet ramp for selections 0 and 5
		ramp_d = (CHANNEL_POWERDOWN_B || !ramp_test) ? 8'h00 :
			 extra_only;
		// Otherwise every lane follows the shared test selection
		test_d = LINK_TEST_PATTERN_SELECT;
	end

	// Lane enable flip-flops
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lane_clk_q <= 8'h00;
			ser_clk_q  <= 8'h00;
			ramp_q     <= 8'h00;
			test_q     <= 4'h0;
		end else begin
			lane_clk_q <= lane_clk_d;
			ser_clk_q  <= ser_clk_d;
			ramp_q     <= ramp_d;
			test_q     <= test_d;
		end
	end

	assign LANE_CLK_EN_B   = lane_clk_q;
	assign SER_CLK_EN_B    = ser_clk_q;
	assign LANE_RAMP_B     = ramp_q;
	assign LANE_TEST_SEL_B = test_q;

	// ----------------------------------------------------------------
	// Sync header selection
	// ----------------------------------------------------------------
	logic       crc_q, crc_d;
	logic       fec_q, fec_d;
	logic [7:0] cmd_q, cmd_d;

	// Only meaningful for 64b/66b formats; reserved codes send neither
	always_comb begin
		crc_d = LINK_FORMAT_IS_64B66B &&
			(sync_hdr_q == jlocfg_pkg::JLOCFG_SH_CRC12);
		fec_d = LINK_FORMAT_IS_64B66B &&
			(sync_hdr_q == jlocfg_pkg::JLOCFG_SH_FEC);
		cmd_d = 8'h00;
	end

	// Sync header flip-flops
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			crc_q <= 1'h0;
			fec_q <= 1'h0;
			cmd_q <= 8'h00;
		end else begin
			crc_q <= crc_d;
			fec_q <= fec_d;
			cmd_q <= cmd_d;
		end
	end

	assign SYNC_CRC12_EN = crc_q;
	assign SYNC_FEC_EN   = fec_q;
	assign SYNC_CMD_BITS = cmd_q;

	// ----------------------------------------------------------------
	// Over-range detection
	// ----------------------------------------------------------------
	logic [3:0]        hit;
	logic [3:0]        pin_q, pin_d;
	logic [3:0]        link_q, link_d;
	logic [HOLD_W-1:0] cnt_q [4];
	logic [HOLD_W-1:0] cnt_d [4];

	// Order: A zero, A one, B zero, B one. Link bits are raw per-cycle
	// compares; pins are stretched and gated by the pin enable
	always_comb begin
		hit[0] = over_hit(SAMPLE_MAG_A, level0_q);
		hit[1] = over_hit(SAMPLE_MAG_A, level1_q);
		hit[2] = over_hit(SAMPLE_MAG_B, level0_q);
		hit[3] = over_hit(SAMPLE_MAG_B, level1_q);
		link_d = hit;
		for (int i = 0; i < 4; i++) begin
			cnt_d[i] = hold_next(hit[i], cnt_q[i], hold_exp_q);
			pin_d[i] = pin_en_q && (hit[i] || (cnt_q[i] != '0));
		end
	end

	// Over-range flip-flops
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_q  <= 4'h0;
			link_q <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				cnt_q[i] <= '0;
			end
		end else begin
			pin_q  <= pin_d;
			link_q <= link_d;
			for (int i = 0; i < 4; i++) begin
				cnt_q[i] <= cnt_d[i];
			end
		end
	end

	assign CHAN_A_OVER_FLAG_ZERO = pin_q[0];
	assign CHAN_A_OVER_FLAG_ONE  = pin_q[1];
	assign CHAN_B_OVER_FLAG_ZERO = pin_q[2];
	assign CHAN_B_OVER_FLAG_ONE  = pin_q[3];
	assign LINK_OVER_BITS_A      = link_q[1:0];
	assign LINK_OVER_BITS_B      = link_q[3:2];

	// LINK_GLOBAL_ENABLE is accepted for completeness; the host keeps
	// it low while changing lane or sync settings, nothing here gates
	logic unused_en;
	assign unused_en = LINK_GLOBAL_ENABLE;

endmodule // jlocfg_top

// ===== sim/jlocfg_properties.sv
// Purpose: Port-level properties of the lane and over-range block.
// Assumes: Sees only the ports of jlocfg_top, one clock domain.
// Notes:   Bound to every jlocfg_top instance below the module.
`timescale 1ns/100ps

module jlocfg_props (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       CHANNEL_POWERDOWN_B,
	input wire logic [7:0] LINK_FORMAT_LANES_B,
	input wire logic       LINK_FORMAT_IS_64B66B,
	input wire logic [3:0] LINK_TEST_PATTERN_SELECT,
	input wire logic [7:0] SAMPLE_MAG_A,
	input wire logic [7:0] LANE_CLK_EN_B,
	input wire logic [7:0] SER_CLK_EN_B,
	input wire logic [7:0] LANE_RAMP_B,
	input wire logic [3:0] LANE_TEST_SEL_B,
	input wire logic       SYNC_CRC12_EN,
	input wire logic       SYNC_FEC_EN,
	input wire logic [7:0] SYNC_CMD_BITS,
	input wire logic [1:0] LINK_OVER_BITS_A,
	input wire logic       CHAN_B_OVER_FLAG_ONE
);
	// ----
	// Properties; past values in a_pd_wins, a_test_copy and a_full_hit are guarded by the reset of the cycle before
	// ----
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	property p_cmd_idle; SYNC_CMD_BITS == 8'h00; endproperty
	a_cmd_idle: assert property (p_cmd_idle)
		else $error("command bits not idle");
	property p_sync_66;
		(SYNC_CRC12_EN || SYNC_FEC_EN) |-> $past(LINK_FORMAT_IS_64B66B)
			&& !(SYNC_CRC12_EN && SYNC_FEC_EN);
	endproperty
	a_sync_66: assert property (p_sync_66)
		else $error("sync word content outside 64b66b");
	property p_pd_wins;
		$past(RST_N) && $past(CHANNEL_POWERDOWN_B) |->
			(LANE_CLK_EN_B | SER_CLK_EN_B | LANE_RAMP_B) == 8'h00;
	endproperty
	a_pd_wins: assert property (p_pd_wins)
		else $error("lane active in power-down");
	// Serializers must sit inside the unbroken run of lanes from lane 0
	property p_ser_chain;
		(SER_CLK_EN_B & ~(LANE_CLK_EN_B & ~(LANE_CLK_EN_B + 8'h01))) == 8'h00;
	endproperty
	a_ser_chain: assert property (p_ser_chain)
		else $error("serializer clocked above a gap");
	property p_ramp_sel;
		LANE_RAMP_B != 8'h00 |-> $past(LINK_TEST_PATTERN_SELECT) inside
			{4'h0, 4'h5} && (LANE_RAMP_B & $past(LINK_FORMAT_LANES_B)) == 8'h00;
	endproperty
	a_ramp_sel: assert property (p_ramp_sel)
		else $error("ramp on wrong lane or test select");
	property p_test_copy;
		$past(RST_N) |-> LANE_TEST_SEL_B == $past(LINK_TEST_PATTERN_SELECT);
	endproperty
	a_test_copy: assert property (p_test_copy)
		else $error("lane test select not followed");
	// Full-scale sample hits any 8-bit level, whatever the pin enable
	property p_full_hit;
		$past(RST_N) && $past(SAMPLE_MAG_A) == 8'hFF |->
			LINK_OVER_BITS_A == 2'h3;
	endproperty
	a_full_hit: assert property (p_full_hit)
		else $error("full-scale sample missed in link bits");
	property p_hold_min;
		$rose(CHAN_B_OVER_FLAG_ONE) |=> CHAN_B_OVER_FLAG_ONE [*7];
	endproperty
	a_hold_min: assert property (p_hold_min)
		else $error("over pin pulse shorter than 8 cycles");
endmodule // jlocfg_props

bind jlocfg_top jlocfg_props i_props (
	.CLK(CLK), .RST_N(RST_N), .CHANNEL_POWERDOWN_B(CHANNEL_POWERDOWN_B),
	.LINK_FORMAT_LANES_B(LINK_FORMAT_LANES_B),
	.LINK_FORMAT_IS_64B66B(LINK_FORMAT_IS_64B66B),
	.LINK_TEST_PATTERN_SELECT(LINK_TEST_PATTERN_SELECT),
	.SAMPLE_MAG_A(SAMPLE_MAG_A), .LANE_CLK_EN_B(LANE_CLK_EN_B),
	.SER_CLK_EN_B(SER_CLK_EN_B), .LANE_RAMP_B(LANE_RAMP_B),
	.LANE_TEST_SEL_B(LANE_TEST_SEL_B), .SYNC_CRC12_EN(SYNC_CRC12_EN),
	.SYNC_FEC_EN(SYNC_FEC_EN), .SYNC_CMD_BITS(SYNC_CMD_BITS),
	.LINK_OVER_BITS_A(LINK_OVER_BITS_A),
	.CHAN_B_OVER_FLAG_ONE(CHAN_B_OVER_FLAG_ONE)
);

// ===== sim/jlocfg_host_model.sv
// Purpose: Host controller stand-in that owns the link enable.
// Assumes: Shares CLK with the block.
// Notes:   Grants a change window only once the link is down.
`timescale 1ns/100ps

module jlocfg_host_model (
	input  wire logic CLK,
	input  wire logic RST_N,
	input  wire logic cfg_req,
	output logic      link_en,
	output logic      cfg_ok
);
	// ----
	// Link drops a cycle after a request, so no change lands while it runs
	// ----
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			link_en <= 1'h0;
		end else begin
			link_en <= !cfg_req;
		end
	end
	assign cfg_ok = cfg_req && !link_en;
endmodule // jlocfg_host_model

// ===== sim/tb_jlocfg_top.sv
// Purpose: Self-checking bench for the lane and over-range block.
// Assumes: Inputs driven on the falling edge; outputs one cycle late.
// Notes:   Drivers queue notes; a watcher compares them after the edge.
`timescale 1ns/100ps
`define JLOCFG_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	bad_count++; $display("wrong value at %0t: got %h want %h", \
	$time, g, e); end end

module tb_jlocfg_top;
	typedef struct {int s; logic [7:0] v;} jlocfg_note_t;
	logic        clk = 1'h0, rst_n = 1'h0, we = 1'h0, re = 1'h0;
	logic        pd = 1'h0, is66 = 1'h0, creq = 1'h0, len, cok;
	logic        crc, fec, a0, a1, b0, b1;
	logic [11:0] addr = 12'h000;
	logic [7:0]  wd = 8'h00, fmt = 8'h00, mag_a = 8'h00, mag_b = 8'h00;
	logic [7:0]  rd, lck, ser, rmp, cmd, x, lv, on, w = 8'h00;
	logic [3:0]  ts = 4'h0, tso;
	logic [1:0]  sh, lba, lbb;
	logic [7:0]  ob [8];
	logic [11:0] ra [6] = '{12'h20B, 12'h20F, 12'h211, 12'h212, 12'h213,
		12'h210};
	logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'hF2, 8'hAB, 8'h07, 8'h00};
	logic [7:0]  rm [6] = '{8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h0F, 8'h00};
	int          bad_count = 0, checks_done = 0;
	jlocfg_note_t nq[$], n;

	jlocfg_top i_dut (
		.CLK(clk), .RST_N(rst_n), .REG_WE(we), .REG_RE(re),
		.REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rd),
		.LINK_GLOBAL_ENABLE(len), .CHANNEL_POWERDOWN_B(pd),
		.LINK_FORMAT_LANES_B(fmt), .LINK_FORMAT_IS_64B66B(is66),
		.LINK_TEST_PATTERN_SELECT(ts), .SAMPLE_MAG_A(mag_a),
		.SAMPLE_MAG_B(mag_b), .LANE_CLK_EN_B(lck), .SER_CLK_EN_B(ser),
		.LANE_RAMP_B(rmp), .LANE_TEST_SEL_B(tso), .SYNC_CRC12_EN(crc),
		.SYNC_FEC_EN(fec), .SYNC_CMD_BITS(cmd), .LINK_OVER_BITS_A(lba),
		.LINK_OVER_BITS_B(lbb), .CHAN_A_OVER_FLAG_ZERO(a0),
		.CHAN_A_OVER_FLAG_ONE(a1), .CHAN_B_OVER_FLAG_ZERO(b0),
		.CHAN_B_OVER_FLAG_ONE(b1)
	);
	jlocfg_host_model i_host (
		.CLK(clk), .RST_N(rst_n), .cfg_req(creq), .link_en(len),
		.cfg_ok(cok)
	);

	// ----
	// Clock, observation table and watcher
	// ----
	initial begin
		forever #5 clk = ~clk;
	end
	always_comb ob = '{rd, lck, ser, rmp, {2'h0, tso, fec, crc}, cmd,
		{lba, lbb, a0, a1, b0, b1}, w};
	// Compare just after the falling edge, once that edge's notes are in
	always @(negedge clk) begin
		#1;
		while (nq.size() > 0) begin
			n = nq.pop_front();
			`JLOCFG_CHK(ob[n.s], n.v)
		end
	end

	// ----
	// Tasks
	// ----
	task automatic ex(int s, logic [7:0] v);
		nq.push_back('{s, v});
	endtask
	// Writes wait for the host model to take the link down first
	task automatic cfgw(logic [11:0] a, logic [7:0] d);
		@(negedge clk);
		creq = 1'h1;
		for (int i = 0; i < 4 && cok !== 1'h1; i++) @(negedge clk);
		we = 1'h1;
		addr = a;
		wd = d;
		@(negedge clk);
		we = 1'h0;
		creq = 1'h0;
	endtask
	task automatic rdchk(logic [11:0] a, logic [7:0] v);
		@(negedge clk);
		re = 1'h1;
		addr = a;
		@(negedge clk);
		re = 1'h0;
		ex(0, v);
	endtask
	// One-cycle sample, then the B one pin width counted at falling edges
	task automatic pulse(logic [7:0] a, b, e6, ew);
		@(negedge clk);
		mag_a = a;
		mag_b = b;
		@(negedge clk);
		mag_a = 8'h00;
		mag_b = 8'h00;
		ex(6, e6);
		w = 8'h00;
		while (b1 === 1'h1 && w < 8'hFF) begin
			w++;
			@(negedge clk);
		end
		ex(7, ew);
	endtask
	function automatic logic [7:0] serx(logic [7:0] l, f, logic s);
		logic [7:0] r, m;
		for (int k = 0; k < 8; k++) begin
			m = 8'((9'h001 << k) - 9'h001);
			r[k] = l[k] & (f[k] | s) & ((l & m) == m);
		end
		return r;
	endfunction
	task automatic final_report();
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		void'($urandom(61016));
		repeat (20) @(negedge clk);
		rst_n = 1'h1;
		foreach (ra[i]) rdchk(ra[i], rv[i]);
		foreach (ra[i]) begin
			cfgw(ra[i], 8'hFF);
			rdchk(ra[i], rm[i]);
		end
		// Random lane, format, test and sync settings
		repeat (24) begin
			x = 8'($urandom);
			sh = 2'($urandom);
			cfgw(12'h20B, x);
			cfgw(12'h20F, {6'h00, sh});
			fmt = 8'($urandom);
			ts = 4'($urandom_range(6, 0));
			pd = ($urandom_range(3, 0) == 0);
			is66 = 1'($urandom);
			repeat (2) @(negedge clk);
			on = fmt | {x[7:1], 1'h0};
			ex(1, pd ? 8'h00 : on);
			ex(2, pd ? 8'h00 : serx(on, fmt, x[0]));
			ex(3, (pd || !(ts inside {4'h0, 4'h5})) ? 8'h00 :
				({x[7:1], 1'h0} & ~fmt));
			ex(4, {2'h0, ts, is66 && sh == 2'h2, is66 && sh == 2'h0});
			ex(5, 8'h00);
		end
		// Hit exactly at the level on B, one below on A
		for (int e = 0; e < 3; e++) begin
			lv = 8'($urandom_range(255, 1));
			cfgw(12'h211, lv);
			cfgw(12'h212, lv);
			rdchk(12'h212, lv);
			cfgw(12'h213, 8'(8 + e));
			pulse(lv - 8'h01, lv, 8'h33, 8'(8 << e));
		end
		// Mirror case: A at the level, B one below, so the A pins rise too
		pulse(lv, lv - 8'h01, 8'hCC, 8'h00);
		cfgw(12'h213, 8'h00);
		pulse(8'hFF, 8'h00, 8'hC0, 8'h00);
		repeat (2) @(negedge clk);
		final_report();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		final_report();
	end
endmodule // tb_jlocfg_top
